//--- rsp_consts.svh
`ifndef RSP_CONSTS_SVH
`define RSP_CONSTS_SVH

// ============================================================
// Register offsets (byte addresses)
`define RSP_OFS_STACK_PTR   12'h000
`define RSP_OFS_TOS         12'h004
`define RSP_OFS_CONFIG      12'h008
`define RSP_OFS_STATUS      12'h00c

// ============================================================
// Field positions
`define RSP_PTR_LSB         0
`define RSP_PTR_MSB         4
`define RSP_UNF_BIT         6
`define RSP_FUL_BIT         7
`define RSP_CFG_OVR_BIT     0
`define RSP_STS_RST_BIT     0

// ============================================================
// Sizes and values
`define RSP_PTR_W           5
`define RSP_PC_W            21
`define RSP_DEPTH           31
`define RSP_PTR_MAX         5'h1f
`define RSP_PTR_ZERO        5'h00
`define RSP_PC_STEP         21'h000002
`define RSP_PC_ZERO         21'h000000
`define RSP_OVR_EN_RST      1'b1
`define RSP_ADDR_W          12

`endif

//--- rsp_pkg.sv
`include "rsp_consts.svh"

package rsp_pkg;

  typedef logic [`RSP_PTR_W-1:0] rsp_ptr_type;
  typedef logic [`RSP_PC_W-1:0]  rsp_pc_type;

  typedef enum logic [2:0] {
    RSP_REG_PTR,
    RSP_REG_TOS,
    RSP_REG_CFG,
    RSP_REG_STS,
    RSP_REG_NONE
  } rsp_reg_type;

  typedef struct packed {
    rsp_ptr_type ptr;
    logic        ovr_en;
    logic        ovr_seen;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    rsp_pc_type  pc_out;
    logic        pc_valid;
    logic        dev_reset;
  } rsp_top_state_type;

  typedef struct packed {
    logic [`RSP_DEPTH-1:0][`RSP_PC_W-1:0] entry;
  } rsp_mem_state_type;

  typedef struct packed {
    logic flag;
  } rsp_flag_state_type;

endpackage

//--- rsp_stack_mem.sv
`timescale 1ns/10ps

module rsp_stack_mem
  import rsp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_en,
  input  wire rsp_ptr_type wr_ptr,
  input  wire rsp_pc_type  wr_data,
  input  wire rsp_ptr_type rd_ptr,
  output rsp_pc_type       rd_data
);

  rsp_mem_state_type st_r;
  rsp_mem_state_type st_nxt;

  // ============================================================
  // Pointer zero has no storage, entry index is pointer minus one
  always_comb begin
    st_nxt = st_r;
    if (wr_en && (wr_ptr != `RSP_PTR_ZERO)) begin
      st_nxt.entry[wr_ptr - 5'h01] = wr_data;
    end
    if (rd_ptr == `RSP_PTR_ZERO) begin
      rd_data = `RSP_PC_ZERO;
    end else begin
      rd_data = st_r.entry[rd_ptr - 5'h01];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // rsp_stack_mem

//--- rsp_sticky_flag.sv
`timescale 1ns/10ps

module rsp_sticky_flag
  import rsp_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_evt,
  input  wire logic clr_evt,
  output logic      flag
);

  rsp_flag_state_type st_r;
  rsp_flag_state_type st_nxt;

  // ============================================================
  // Set wins over clear; only power-on reset clears otherwise
  always_comb begin
    st_nxt = st_r;
    if (clr_evt) begin
      st_nxt.flag = 1'b0;
    end
    if (set_evt) begin
      st_nxt.flag = 1'b1;
    end
    flag = st_r.flag;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // rsp_sticky_flag

//--- rsp_return_stack.sv
`timescale 1ns/10ps

module rsp_return_stack
  import rsp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        soft_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        push_req,
  input  wire logic        pop_req,
  input  wire rsp_pc_type  pc_in,
  output rsp_pc_type       pc_out,
  output logic             pc_valid,
  output logic             device_reset,
  output rsp_ptr_type      stack_pointer,
  output logic             stack_full_flag,
  output logic             stack_underflow_flag
);

  // ============================================================
  // Helpers
  function automatic rsp_reg_type rsp_decode(input logic [11:0] addr);
    unique case (addr)
      `RSP_OFS_STACK_PTR: rsp_decode = RSP_REG_PTR;
      `RSP_OFS_TOS:       rsp_decode = RSP_REG_TOS;
      `RSP_OFS_CONFIG:    rsp_decode = RSP_REG_CFG;
      `RSP_OFS_STATUS:    rsp_decode = RSP_REG_STS;
      default:            rsp_decode = RSP_REG_NONE;
    endcase
  endfunction

  function automatic rsp_ptr_type rsp_step(input rsp_ptr_type p, input logic up);
    if (up) begin
      rsp_step = (p == `RSP_PTR_MAX) ? p : p + 5'h01;
    end else begin
      rsp_step = (p == `RSP_PTR_ZERO) ? p : p - 5'h01;
    end
  endfunction

  // ============================================================
  // State and wires
  rsp_top_state_type st_r;
  rsp_top_state_type st_nxt;

  rsp_pc_type   mem_rd_data;
  logic         mem_wr_en;
  rsp_ptr_type  mem_wr_ptr;
  rsp_pc_type   mem_wr_data;
  logic         full_set;
  logic         full_clr;
  logic         unf_set;
  logic         unf_clr;
  logic         full_q;
  logic         unf_q;
  logic         apb_setup;
  logic         apb_write;
  rsp_reg_type  sel_reg;
  rsp_reg_type  acc_reg;
  rsp_ptr_type  ptr_up;

  // ============================================================
  // Storage and sticky flags
  rsp_stack_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (mem_wr_en),
    .wr_ptr  (mem_wr_ptr),
    .wr_data (mem_wr_data),
    .rd_ptr  (st_r.ptr),
    .rd_data (mem_rd_data)
  );

  rsp_sticky_flag u_full (
    .pclk    (pclk),
    .presetn (presetn),
    .set_evt (full_set),
    .clr_evt (full_clr),
    .flag    (full_q)
  );

  rsp_sticky_flag u_unf (
    .pclk    (pclk),
    .presetn (presetn),
    .set_evt (unf_set),
    .clr_evt (unf_clr),
    .flag    (unf_q)
  );

  // ============================================================
  // Next state
  always_comb begin
    st_nxt      = st_r;
    mem_wr_en   = 1'b0;
    mem_wr_ptr  = st_r.ptr;
    mem_wr_data = pc_in;
    full_set    = 1'b0;
    full_clr    = 1'b0;
    unf_set     = 1'b0;
    unf_clr     = 1'b0;
    ptr_up      = rsp_step(st_r.ptr, 1'b1);
    apb_setup   = psel && !penable;
    apb_write   = psel && penable && pwrite && st_r.pready && !st_r.pslverr;
    sel_reg     = rsp_decode(paddr);
    acc_reg     = apb_write ? sel_reg : RSP_REG_NONE;

    st_nxt.pc_valid  = 1'b0;
    st_nxt.dev_reset = 1'b0;

    // APB setup: answer is prepared for the access edge
    if (apb_setup) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = (sel_reg == RSP_REG_NONE);
      st_nxt.prdata  = 32'h0000_0000;
      unique case (sel_reg)
        RSP_REG_PTR: begin
          st_nxt.prdata[`RSP_PTR_MSB:`RSP_PTR_LSB] = st_r.ptr;
          st_nxt.prdata[`RSP_UNF_BIT] = unf_q;
          st_nxt.prdata[`RSP_FUL_BIT] = full_q;
        end
        RSP_REG_TOS: begin
          st_nxt.prdata[`RSP_PC_W-1:0] = mem_rd_data;
        end
        RSP_REG_CFG: begin
          st_nxt.prdata[`RSP_CFG_OVR_BIT] = st_r.ovr_en;
        end
        RSP_REG_STS: begin
          st_nxt.prdata[`RSP_STS_RST_BIT] = st_r.ovr_seen;
        end
        RSP_REG_NONE: begin
          st_nxt.prdata = 32'h0000_0000;
        end
      endcase
    end else if (psel && penable) begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
    end

    // Software writes
    unique case (acc_reg)
      RSP_REG_PTR: begin
        st_nxt.ptr = pwdata[`RSP_PTR_MSB:`RSP_PTR_LSB];
        full_clr   = !pwdata[`RSP_FUL_BIT];
        unf_clr    = !pwdata[`RSP_UNF_BIT];
      end
      RSP_REG_TOS: begin
        mem_wr_en   = 1'b1;
        mem_wr_ptr  = st_r.ptr;
        mem_wr_data = pwdata[`RSP_PC_W-1:0];
      end
      RSP_REG_CFG: begin
        st_nxt.ovr_en = pwdata[`RSP_CFG_OVR_BIT];
      end
      RSP_REG_STS: begin
        if (pwdata[`RSP_STS_RST_BIT]) begin
          st_nxt.ovr_seen = 1'b0;
        end
      end
      RSP_REG_NONE: begin
        st_nxt.ovr_seen = st_r.ovr_seen;
      end
    endcase

    // Core push and pop; push has priority, core wins over software
    if (push_req) begin
      mem_wr_en  = 1'b1;
      mem_wr_ptr = ptr_up;
      st_nxt.ptr = ptr_up;
      if (ptr_up == `RSP_PTR_MAX) begin
        full_set = 1'b1;
        if (st_r.ovr_en) begin
          mem_wr_data      = pc_in + `RSP_PC_STEP;
          st_nxt.dev_reset = 1'b1;
          st_nxt.ovr_seen  = 1'b1;
          st_nxt.ptr       = `RSP_PTR_ZERO;
        end else begin
          mem_wr_data = pc_in;
          if (st_r.ptr == `RSP_PTR_MAX) begin
            mem_wr_ptr = `RSP_PTR_MAX;
          end
        end
      end
    end else if (pop_req) begin
      st_nxt.pc_valid = 1'b1;
      st_nxt.pc_out   = mem_rd_data;
      if (st_r.ptr == `RSP_PTR_ZERO) begin
        st_nxt.pc_out = `RSP_PC_ZERO;
        unf_set       = 1'b1;
      end
      st_nxt.ptr = rsp_step(st_r.ptr, 1'b0);
    end

    // Non power-on resets clear the pointer only
    if (soft_reset) begin
      st_nxt.ptr = `RSP_PTR_ZERO;
    end
  end

  // ============================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= '0;
      st_r.ovr_en <= `RSP_OVR_EN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // Outputs
  assign prdata               = st_r.prdata;
  assign pready               = st_r.pready;
  assign pslverr              = st_r.pslverr;
  assign pc_out               = st_r.pc_out;
  assign pc_valid             = st_r.pc_valid;
  assign device_reset         = st_r.dev_reset;
  assign stack_pointer        = st_r.ptr;
  assign stack_full_flag      = full_q;
  assign stack_underflow_flag = unf_q;

endmodule // rsp_return_stack

//--- rsp_return_stack_asserts.sv
`timescale 1ns/10ps
// ============================================================
// Return stack checker
module rsp_return_stack_asserts
  import rsp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        soft_reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        push_req,
  input wire logic        pop_req,
  input wire rsp_pc_type  pc_out,
  input wire logic        pc_valid,
  input wire logic        device_reset,
  input wire rsp_ptr_type stack_pointer,
  input wire logic        stack_full_flag,
  input wire logic        stack_underflow_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic sw_wr = psel && penable && pready && pwrite && paddr == 12'h000;
  sequence s_push; push_req && !soft_reset; endsequence
  sequence s_pop; pop_req && !push_req && !soft_reset; endsequence
  a_push_step:
    assert property (s_push ##0 stack_pointer < 5'h1e |=>
      stack_pointer == $past(stack_pointer) + 5'h01) else $error("push step wrong");
  a_pop_step:
    assert property (s_pop ##0 stack_pointer != 5'h00 |=>
      pc_valid && stack_pointer == $past(stack_pointer) - 5'h01) else $error("pop step wrong");
  a_pop_empty:
    assert property (s_pop ##0 stack_pointer == 5'h00 |=> pc_valid && pc_out == 21'h000000
      && stack_pointer == 5'h00 && stack_underflow_flag) else $error("empty pop wrong");
  a_soft_zero:
    assert property (soft_reset |=> stack_pointer == 5'h00) else $error("soft reset kept ptr");
  a_full_set:
    assert property (s_push ##0 stack_pointer == 5'h1e |=> stack_full_flag)
      else $error("full not set");
  a_full_hold:
    assert property (stack_full_flag && !sw_wr |=> stack_full_flag) else $error("full lost");
  a_unf_hold:
    assert property (stack_underflow_flag && !sw_wr |=> stack_underflow_flag)
      else $error("underflow lost");
  a_ovr_reset:
    assert property (device_reset |-> stack_pointer == 5'h00 && stack_full_flag
      && $past(push_req)) else $error("overflow reset wrong");
  a_top_hold:
    assert property (s_push ##0 stack_pointer == 5'h1f |=> stack_pointer == 5'h1f)
      else $error("top not held");
  a_pc_pulse:
    assert property (pc_valid |-> $past(pop_req) && !$past(push_req))
      else $error("stray pc_valid");
endmodule // rsp_return_stack_asserts

bind rsp_return_stack rsp_return_stack_asserts u_chk (.pclk, .presetn, .soft_reset, .psel,
  .penable, .pwrite, .paddr, .pready, .push_req, .pop_req, .pc_out, .pc_valid,
  .device_reset, .stack_pointer, .stack_full_flag, .stack_underflow_flag);

//--- rsp_core_model.sv
`timescale 1ns/10ps
// ============================================================
// Processor core: calls push, returns pop
module rsp_core_model
  import rsp_pkg::*;
(
  input  wire logic       pclk,
  input  wire rsp_pc_type pc_out,
  input  wire logic       pc_valid,
  output logic            push_req,
  output logic            pop_req,
  output rsp_pc_type      pc_in
);
  initial begin
    push_req = 1'b0;
    pop_req  = 1'b0;
    pc_in    = 21'h000000;
  end
  task automatic push_n(input rsp_pc_type base, input int n);
    push_req <= 1'b1;
    for (int i = 0; i < n; i++) begin
      pc_in <= base + rsp_pc_type'(i);
      @(posedge pclk);
    end
    push_req <= 1'b0;
    pc_in    <= ~pc_in;
  endtask
  task automatic ret_op(input int gap, output rsp_pc_type pc, output logic ok);
    repeat (gap) @(posedge pclk);
    pop_req <= 1'b1;
    @(posedge pclk);
    pop_req <= 1'b0;
    @(posedge pclk);
    ok = pc_valid;
    pc = pc_out;
  endtask
endmodule // rsp_core_model

//--- tb_top.sv
`timescale 1ns/10ps
// ============================================================
// Testbench
module tb_top import rsp_pkg::*;;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        soft_reset = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic        pready, pslverr, pc_valid, device_reset, e, ok;
  logic        push_req, pop_req, stack_full_flag, stack_underflow_flag;
  rsp_pc_type  pc_in, pc_out, pc;
  rsp_ptr_type stack_pointer;
  rsp_pc_type  m [32];
  logic [31:0] seed = 32'h0001_1b3f;
  int          err_count = 0;
  int          compares = 0;
  int          p, v;

  always #5 pclk = ~pclk;

  rsp_return_stack DUT (.pclk, .presetn, .soft_reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .push_req, .pop_req, .pc_in, .pc_out, .pc_valid,
    .device_reset, .stack_pointer, .stack_full_flag, .stack_underflow_flag);
  rsp_core_model core (.pclk, .pc_out, .pc_valid, .push_req, .pop_req, .pc_in);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] pins();
    return {23'h0, device_reset, stack_full_flag, stack_underflow_flag, 1'b0, stack_pointer};
  endfunction
  function automatic logic [31:0] ptr_word(input int q, input logic u, input logic f);
    return {24'h0, f, u, 1'b0, q[4:0]};
  endfunction
  task automatic report_and_stop();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, r, x);
  endtask
  task automatic soft_pulse();
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd("cfg", 12'h008, 32'h1);
    rd("ptr", 12'h000, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    apb(1'b1, 12'h014, 32'hffff_ffff);
    chk("slverr_w", {31'h0, e}, 32'h1);
    rd("ptr_kept", 12'h000, 32'h0);
    // ============================================================
    // Overflow reset off: fill, overwrite top, drain, underflow
    apb(1'b1, 12'h008, 32'h0);
    r = rnd();
    pc = r[20:0];
    core.push_n(pc, 31);
    @(posedge pclk);
    chk("pins", pins(), ptr_word(31, 1'b0, 1'b1));
    for (p = 1; p < 32; p++) m[p] = pc + rsp_pc_type'(p - 1);
    rd("ptr", 12'h000, ptr_word(31, 1'b0, 1'b1));
    rd("tos", 12'h004, {11'h0, m[31]});
    r = rnd();
    core.push_n(r[20:0], 2);
    m[31] = r[20:0] + 21'h1;
    rd("ptr", 12'h000, ptr_word(31, 1'b0, 1'b1));
    for (p = 31; p > 0; p--) begin
      core.ret_op(p % 3, pc, ok);
      chk("pop", {10'h0, ok, pc}, {10'h0, 1'b1, m[p]});
    end
    core.ret_op(0, pc, ok);
    chk("pop0", {10'h0, ok, pc}, 32'h0020_0000);
    rd("ptr", 12'h000, ptr_word(0, 1'b1, 1'b1));
    apb(1'b1, 12'h000, 32'h0);
    rd("ptr", 12'h000, 32'h0);
    // ============================================================
    // Overflow reset on, then pointer written by software
    apb(1'b1, 12'h008, 32'h1);
    r = rnd();
    pc = r[20:0];
    core.push_n(pc, 31);
    @(posedge pclk);
    chk("pins", pins(), 32'h100 | ptr_word(0, 1'b0, 1'b1));
    rd("ptr", 12'h000, ptr_word(0, 1'b0, 1'b1));
    rd("sts", 12'h00c, 32'h1);
    apb(1'b1, 12'h00c, 32'h1);
    rd("sts_clr", 12'h00c, 32'h0);
    apb(1'b1, 12'h000, 32'h9f);
    rd("top", 12'h004, {11'h0, pc + 21'h20});
    r = rnd();
    v = 1 + int'(r % 32'h1e);
    m[1] = pc + rsp_pc_type'(v - 1);
    apb(1'b1, 12'h000, 32'h80 | 32'(v));
    rd("tos", 12'h004, {11'h0, m[1]});
    r = rnd();
    m[1] = r[20:0];
    apb(1'b1, 12'h004, r);
    rd("tos_w", 12'h004, {11'h0, m[1]});
    core.ret_op(1, pc, ok);
    chk("pop", {10'h0, ok, pc}, {10'h0, 1'b1, m[1]});
    rd("ptr", 12'h000, ptr_word(v - 1, 1'b0, 1'b1));
    apb(1'b1, 12'h000, 32'h9e);
    soft_pulse();
    rd("ptr", 12'h000, ptr_word(0, 1'b0, 1'b1));
    core.ret_op(0, pc, ok);
    chk("pins", pins(), ptr_word(0, 1'b1, 1'b1));
    apb(1'b1, 12'h008, 32'h0);
    // ============================================================
    // Power-on reset in mid-run clears flags and sets config back to its reset value 1
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("por", pins(), 32'h0);
    rd("cfg", 12'h008, 32'h1);
    report_and_stop();
  end
endmodule // tb_top
